// >>> wdg_top.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// =====================================================================
// Overview of operation
// RULE1 - eighteen-bit up counter advances once per watchdog clock period
// RULE2 - run bit 7 set starts the counter counting upward
// RULE3 - reaching the interval sets the time-out flag; irq only when enabled
// RULE4 - every time-out opens a 1024-period window where a clear still saves
// RULE5 - bit 0 write zeroes the counter; bit drops by itself afterwards
// RULE6 - select bits 10:8 pick interval two to the 4,6,...,18 periods
// RULE7 - window ends without clear: set bark flag and assert chip reset
// RULE8 - chip reset stays high exactly 63 watchdog periods
// RULE9 - bark flag survives the chip reset for later polling
// RULE10 - powered down with wake enable bit 4: time-out wakes the chip
// RULE11 - after wake, missing clear within 1024 periods resets the chip
// RULE12 - chip reset only while reset enable bit 1 is set
// RULE13 - both flags clear on writing one; writing zero does nothing
module wdg_top #(
    parameter int CNT_W = wdg_pkg::CNT_BITS,
    parameter int GRACE_N = wdg_pkg::GRACE_TICKS,
    parameter int BARK_N = wdg_pkg::BARK_TICKS
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic WATCHDOG_CLOCK,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic POWER_DOWN,
    output logic IRQ,
    output logic WAKE,
    output logic CHIP_RST
);
    localparam int MAX_EXP = wdg_pkg::EXP_BASE + 7 * wdg_pkg::EXP_STEP;
    localparam int GW = $clog2(GRACE_N + 1);
    localparam int BW = $clog2(BARK_N + 1);

    // =================================================================
    // elaboration checks
    generate
        if (CNT_W != MAX_EXP) begin : g_bad_width
            $error("counter width must match the longest interval");
        end
        if (GRACE_N < 2 || GRACE_N > 4096 || BARK_N < 2 || BARK_N > 4096) begin : g_bad_cnt
            $error("grace and reset lengths must lie in 2..4096");
        end
    endgenerate

    // =================================================================
    // declarations
    logic tick;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W:0] cnt_inc;
    logic clr_pend_r;
    logic run_r;
    logic rst_en_r;
    logic wake_en_r;
    logic irq_en_r;
    logic [2:0] sel_r;
    logic [2:0] stat_r;
    logic [2:0] stat_nxt;
    logic [2:0] mask_r;
    wdg_pkg::wdg_phase_t phase_r;
    logic [GW-1:0] grace_r;
    logic [BW-1:0] bark_r;
    logic timeout_hit;
    logic grace_end;
    logic bark_end;
    logic wake_r;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic [2:0] stat_set;
    logic [2:0] stat_clr;

    // interval in periods for a select code, one bit past the counter
    function automatic logic [CNT_W:0] interval_of(input logic [2:0] sel);
        logic [4:0] expo;
        expo = 5'(wdg_pkg::EXP_BASE) + {1'b0, sel, 1'b0};
        interval_of = (CNT_W+1)'(1) << expo;
    endfunction

    // =================================================================
    // watchdog clock edge detection
    wdg_tick_sync u_tick (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .async_in(WATCHDOG_CLOCK),
        .tick(tick)
    );

    // =================================================================
    // write decode
    always_comb begin
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (WR && ADDR == wdg_pkg::ADDR_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (WR && ADDR == wdg_pkg::ADDR_STAT) begin
            wr_stat = 1'b1;
        end else if (WR && ADDR == wdg_pkg::ADDR_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // =================================================================
    // time-out detection; next count is one bit wider so code 111 fits
    assign cnt_inc = {1'b0, cnt_r} + (CNT_W+1)'(1);
    assign timeout_hit = tick & run_r & ~clr_pend_r & (phase_r != wdg_pkg::WDG_BARK)
                       & (cnt_inc == interval_of(sel_r)); // RULE3 RULE6
    assign grace_end = tick & (phase_r == wdg_pkg::WDG_GRACE) & ~clr_pend_r
                     & (grace_r == GW'(GRACE_N - 1));
    assign bark_end = tick & (phase_r == wdg_pkg::WDG_BARK) & (bark_r == BW'(BARK_N - 1));

    // =================================================================
    // counter: clear wins over counting, free-running wrap otherwise
    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_r <= '0;
        end else if (CE) begin
            if (bark_end) begin
                cnt_r <= '0;
            end else if (tick && clr_pend_r) begin
                cnt_r <= '0; // RULE5
            end else if (tick && run_r && phase_r != wdg_pkg::WDG_BARK) begin
                cnt_r <= cnt_inc[CNT_W-1:0]; // RULE1 RULE2
            end
        end
    end

    // =================================================================
    // clear request: held until a watchdog period applies it
    always_ff @(posedge CLK) begin
        if (RST) begin
            clr_pend_r <= 1'b0;
        end else if (CE) begin
            if (wr_ctrl && WDATA[wdg_pkg::CTRL_CLR_BIT]) begin
                clr_pend_r <= 1'b1;
            end else if (tick || bark_end) begin
                clr_pend_r <= 1'b0; // RULE5
            end
        end
    end

    // =================================================================
    // control bits; the chip reset returns them to defaults
    always_ff @(posedge CLK) begin
        if (RST) begin
            run_r <= 1'b0;
            rst_en_r <= 1'b0;
            wake_en_r <= 1'b0;
            irq_en_r <= 1'b0;
            sel_r <= wdg_pkg::SEL_RESET;
        end else if (CE) begin
            if (bark_end) begin
                run_r <= 1'b0;
                rst_en_r <= 1'b0;
                wake_en_r <= 1'b0;
                irq_en_r <= 1'b0;
                sel_r <= wdg_pkg::SEL_RESET;
            end else if (wr_ctrl) begin
                run_r <= WDATA[wdg_pkg::CTRL_RUN_BIT];
                rst_en_r <= WDATA[wdg_pkg::CTRL_RSTEN_BIT];
                wake_en_r <= WDATA[wdg_pkg::CTRL_WAKEEN_BIT];
                irq_en_r <= WDATA[wdg_pkg::CTRL_IRQEN_BIT];
                sel_r <= WDATA[wdg_pkg::CTRL_SEL_LSB +: wdg_pkg::CTRL_SEL_W];
            end
        end
    end

    // =================================================================
    // grace window and chip reset sequencing
    always_ff @(posedge CLK) begin
        if (RST) begin
            phase_r <= wdg_pkg::WDG_IDLE;
            grace_r <= '0;
            bark_r <= '0;
        end else if (CE) begin
            case (phase_r)
                wdg_pkg::WDG_IDLE: begin
                    if (timeout_hit) begin
                        phase_r <= wdg_pkg::WDG_GRACE; // RULE4 RULE11
                        grace_r <= '0;
                    end
                end
                wdg_pkg::WDG_GRACE: begin
                    if (tick && clr_pend_r) begin
                        phase_r <= wdg_pkg::WDG_IDLE; // RULE4
                    end else if (timeout_hit) begin
                        grace_r <= '0;
                    end else if (grace_end && rst_en_r) begin
                        phase_r <= wdg_pkg::WDG_BARK; // RULE7 RULE11 RULE12
                        bark_r <= '0;
                    end else if (grace_end) begin
                        phase_r <= wdg_pkg::WDG_IDLE; // RULE12
                    end else if (tick) begin
                        grace_r <= grace_r + GW'(1);
                    end
                end
                wdg_pkg::WDG_BARK: begin
                    if (bark_end) begin
                        phase_r <= wdg_pkg::WDG_IDLE; // RULE8
                    end else if (tick) begin
                        bark_r <= bark_r + BW'(1);
                    end
                end
                default: begin
                    phase_r <= wdg_pkg::WDG_IDLE;
                end
            endcase
        end
    end

    // chip reset is a plain decode of the phase, free of glitches
    assign CHIP_RST = (phase_r == wdg_pkg::WDG_BARK); // RULE8

    // =================================================================
    // sticky flags: set wins over a write-one clear
    always_comb begin
        stat_set = '0;
        stat_set[wdg_pkg::STAT_TOUT_BIT] = timeout_hit;
        stat_set[wdg_pkg::STAT_BARK_BIT] = grace_end & rst_en_r;
        stat_set[wdg_pkg::STAT_WAKE_BIT] = timeout_hit & POWER_DOWN & wake_en_r;
        stat_clr = '0;
        if (wr_stat) begin
            stat_clr = WDATA[2:0];
        end else if (wr_ctrl) begin
            stat_clr[wdg_pkg::STAT_TOUT_BIT] = WDATA[wdg_pkg::CTRL_TFLAG_BIT];
            stat_clr[wdg_pkg::STAT_BARK_BIT] = WDATA[wdg_pkg::CTRL_BARK_BIT];
        end
        stat_nxt = stat_set | (stat_r & ~stat_clr); // RULE13
    end

    // flags are not touched by the chip reset, only by RST
    always_ff @(posedge CLK) begin
        if (RST) begin
            stat_r <= '0;
        end else if (CE) begin
            stat_r <= stat_nxt; // RULE3 RULE9
        end
    end

    // =================================================================
    // interrupt mask
    always_ff @(posedge CLK) begin
        if (RST) begin
            mask_r <= wdg_pkg::MASK_RESET;
        end else if (CE && wr_mask) begin
            mask_r <= WDATA[2:0];
        end
    end

    // time-out source also needs the enable bit in the control register
    assign IRQ = (stat_r[wdg_pkg::STAT_TOUT_BIT] & mask_r[wdg_pkg::STAT_TOUT_BIT] & irq_en_r)
               | (|(stat_r[2:1] & mask_r[2:1])); // RULE3

    // =================================================================
    // wake-up pulse to the power manager
    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_r <= 1'b0;
        end else if (CE) begin
            wake_r <= timeout_hit & POWER_DOWN & wake_en_r; // RULE10
        end
    end

    assign WAKE = wake_r;

    // =================================================================
    // read port, data one cycle after the strobe, zero elsewhere
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= '0;
        end else if (CE) begin
            RDATA <= '0;
            if (RD && ADDR == wdg_pkg::ADDR_CTRL) begin
                RDATA[wdg_pkg::CTRL_CLR_BIT] <= clr_pend_r;
                RDATA[wdg_pkg::CTRL_RSTEN_BIT] <= rst_en_r;
                RDATA[wdg_pkg::CTRL_BARK_BIT] <= stat_r[wdg_pkg::STAT_BARK_BIT];
                RDATA[wdg_pkg::CTRL_TFLAG_BIT] <= stat_r[wdg_pkg::STAT_TOUT_BIT];
                RDATA[wdg_pkg::CTRL_WAKEEN_BIT] <= wake_en_r;
                RDATA[wdg_pkg::CTRL_IRQEN_BIT] <= irq_en_r;
                RDATA[wdg_pkg::CTRL_RUN_BIT] <= run_r;
                RDATA[wdg_pkg::CTRL_SEL_LSB +: wdg_pkg::CTRL_SEL_W] <= sel_r;
            end else if (RD && ADDR == wdg_pkg::ADDR_STAT) begin
                RDATA[2:0] <= stat_r;
            end else if (RD && ADDR == wdg_pkg::ADDR_MASK) begin
                RDATA[2:0] <= mask_r;
            end else if (RD && ADDR == wdg_pkg::ADDR_CNT) begin
                RDATA[CNT_W-1:0] <= cnt_r;
            end
        end
    end

    // =================================================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST || !CE);

    a_count_step: assert property (tick && run_r && !clr_pend_r && !CHIP_RST
        |=> cnt_r == $past(cnt_r) + CNT_W'(1)) // RULE1
        else $error("counter did not advance by one");
    a_count_hold: assert property (!tick && !bark_end |=> $stable(cnt_r)) // RULE2
        else $error("counter moved without a watchdog period");
    a_timeout_flag: assert property (timeout_hit |=> stat_r[wdg_pkg::STAT_TOUT_BIT]
        && phase_r == wdg_pkg::WDG_GRACE) // RULE3
        else $error("time-out flag or window missing");
    a_clear_apply: assert property (tick && clr_pend_r |=> cnt_r == '0 && !clr_pend_r) // RULE5
        else $error("clear not applied or not dropped");
    a_bark_enable: assert property ($rose(CHIP_RST) |-> $past(rst_en_r)
        && $past(grace_r) == GW'(GRACE_N - 1)) // RULE7
        else $error("chip reset without enable or early");
    a_bark_length: assert property (CHIP_RST && tick && bark_r == BW'(BARK_N - 1)
        |=> !CHIP_RST) // RULE8
        else $error("chip reset length wrong");
    a_bark_keep: assert property ($fell(CHIP_RST) |-> stat_r[wdg_pkg::STAT_BARK_BIT]
        || $past(wr_stat) || $past(wr_ctrl)) // RULE9
        else $error("bark flag lost across chip reset");
    a_wake_cause: assert property (WAKE |-> $past(POWER_DOWN) && $past(wake_en_r)
        && $past(timeout_hit)) // RULE10
        else $error("wake without powered-down time-out");
    a_w1c_zero: assert property (wr_stat && WDATA[2:0] == 3'h0 && stat_set == 3'h0
        |=> stat_r == $past(stat_r)) // RULE13
        else $error("writing zero changed a flag");
    a_rd_unmapped: assert property (RD && ADDR > wdg_pkg::ADDR_CNT |=> RDATA == '0)
        else $error("unmapped read not zero");
    // no set flag means no request, whatever the mask and enable hold
    a_irq_quiet: assert property (stat_r == 3'h0 |-> !IRQ) // RULE3
        else $error("interrupt without a set flag");
    a_grace_save: assert property (phase_r == wdg_pkg::WDG_GRACE && tick && clr_pend_r
        |=> phase_r == wdg_pkg::WDG_IDLE && !CHIP_RST) // RULE4
        else $error("clear in grace window did not save the chip");
    a_no_bark_off: assert property (grace_end && !rst_en_r |=> !CHIP_RST) // RULE12
        else $error("chip reset while reset enable is off");
    a_short_interval: assert property (timeout_hit && sel_r == 3'h0
        |=> cnt_r == (CNT_W'(1) << wdg_pkg::EXP_BASE)) // RULE6
        else $error("shortest interval not sixteen periods");

    c_timeout: cover property (timeout_hit);
    c_saved: cover property (phase_r == wdg_pkg::WDG_GRACE ##1 phase_r == wdg_pkg::WDG_IDLE);
    c_bark: cover property ($fell(CHIP_RST));
    c_wake: cover property (WAKE);

endmodule // wdg_top

// >>> wdg_pkg.sv
// =====================================================================
// watchdog shared constants
package wdg_pkg;

    // =================================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_CNT = 8'h0c;

    // =================================================================
    // control register field positions
    localparam int CTRL_CLR_BIT = 0;
    localparam int CTRL_RSTEN_BIT = 1;
    localparam int CTRL_BARK_BIT = 2;
    localparam int CTRL_TFLAG_BIT = 3;
    localparam int CTRL_WAKEEN_BIT = 4;
    localparam int CTRL_IRQEN_BIT = 6;
    localparam int CTRL_RUN_BIT = 7;
    localparam int CTRL_SEL_LSB = 8;
    localparam int CTRL_SEL_W = 3;

    // =================================================================
    // status / mask layout
    localparam int STAT_W = 3;
    localparam int STAT_TOUT_BIT = 0;
    localparam int STAT_BARK_BIT = 1;
    localparam int STAT_WAKE_BIT = 2;
    localparam logic [2:0] MASK_RESET = 3'h7;
    localparam logic [2:0] SEL_RESET = 3'h0;

    // =================================================================
    // timing, counted in watchdog clock periods
    localparam int CNT_BITS = 18;
    localparam int GRACE_TICKS = 1024;
    localparam int BARK_TICKS = 63;
    localparam int EXP_BASE = 4;
    localparam int EXP_STEP = 2;

    // =================================================================
    // sequencing phases
    typedef enum logic [1:0] {
        WDG_IDLE,
        WDG_GRACE,
        WDG_BARK
    } wdg_phase_t;

endpackage

// >>> wdg_tick_sync.sv
`timescale 1ns/10ps
// =====================================================================
// brings the slow watchdog clock into CLK and marks each rising edge
module wdg_tick_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic async_in,
    output logic tick
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // =================================================================
    // two-stage synchroniser, then one more stage for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (ce) begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // edge seen only on settled stages; meta_r feeds sync_r alone
    assign tick = ce & sync_r & ~prev_r;

endmodule // wdg_tick_sync

// >>> wdg_partner.sv
`timescale 1ns/10ps
// =====================================================================
// far side: slow clock source, power manager and chip reset generator
module wdg_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep,
    input wire logic chip_rst,
    input wire logic wake,
    output logic wd_clk,
    output logic power_down,
    output int rst_len,
    output int rst_cnt,
    output int wake_cnt
);
    logic [2:0] div_r = 3'h0;
    logic was_rst_r;
    int cur_r;

    // =================================================================
    // slow clock runs free, 4 cycles high and 4 low, so each half
    // clears the 3-cycle minimum of the synchroniser
    always_ff @(posedge clk) begin
        div_r <= div_r + 3'h1;
    end
    assign wd_clk = div_r[2];

    // =================================================================
    // reset generator: measures each chip reset in slow clock rises
    always_ff @(posedge clk) begin
        was_rst_r <= chip_rst;
        if (rst) begin
            cur_r <= 0;
            rst_len <= 0;
            rst_cnt <= 0;
        end else if (chip_rst) begin
            cur_r <= cur_r + ((div_r == 3'h3) ? 1 : 0);
        end else if (was_rst_r) begin
            rst_len <= cur_r;
            rst_cnt <= rst_cnt + 1;
            cur_r <= 0;
        end
    end

    // =================================================================
    // power manager: a wake pulse ends power-down at once
    always_ff @(posedge clk) begin
        if (rst) begin
            power_down <= 1'b0;
            wake_cnt <= 0;
        end else if (wake) begin
            power_down <= 1'b0;
            wake_cnt <= wake_cnt + 1;
        end else if (sleep) begin
            power_down <= 1'b1;
        end
    end
endmodule // wdg_partner

// >>> wdg_top_tb.sv
`timescale 1ns/10ps
// =====================================================================
// self-checking bench with short grace and reset counts
module wdg_top_tb;
    localparam int GRACE = 4;
    localparam int BARK = 4;
    logic clk, rst, wr, rd, irq, wake, chip_rst, wd_clk, power_down, sleep;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v, lfsr;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int n, rst_len, rst_cnt, wake_cnt;

    wdg_top #(.GRACE_N(GRACE), .BARK_N(BARK)) DUT (.CLK(clk), .RST(rst), .CE(1'b1),
        .WATCHDOG_CLOCK(wd_clk), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .POWER_DOWN(power_down), .IRQ(irq), .WAKE(wake), .CHIP_RST(chip_rst));
    wdg_partner far_end (.clk(clk), .rst(rst), .sleep(sleep), .chip_rst(chip_rst),
        .wake(wake), .wd_clk(wd_clk), .power_down(power_down), .rst_len(rst_len),
        .rst_cnt(rst_cnt), .wake_cnt(wake_cnt));

    // =================================================================
    // clock, hang guard well above the ~12k cycles the tests need
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            summarize();
        end
    end

    // =================================================================
    // helpers
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd32(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        chk(v, exp);
    endtask
    // 0: irq high, 1: chip reset high, 2: chip reset low; n = cycles waited
    task automatic wait_for(input int which, input int lim);
        n = 0;
        while (n < lim && !((which == 0 && irq === 1'b1) || (which == 1 && chip_rst === 1'b1)
               || (which == 2 && chip_rst === 1'b0))) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n < lim, 1);
    endtask
    task automatic summarize;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // =================================================================
    // main sequence; the model is the interval 2**(4+2*sel) in ticks
    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        sleep = 1'b0;
        lfsr = 32'ha21b;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd32(wdg_pkg::ADDR_CTRL, 32'h0);
        rd32(wdg_pkg::ADDR_STAT, 32'h0);
        rd32(wdg_pkg::ADDR_MASK, 32'h7);
        rd32(wdg_pkg::ADDR_CNT, 32'h0);
        $display("test reset values done");
        // run with irq enable and clear, each of the shorter intervals
        for (int s = 0; s < 4; s++) begin
            wr32(wdg_pkg::ADDR_STAT, 32'h7);
            wr32(wdg_pkg::ADDR_CTRL, 32'hc1 | (s << 8));
            repeat (24) @(posedge clk);
            rd32(wdg_pkg::ADDR_CTRL, 32'hc0 | (s << 8));
            wait_for(0, 8 * (1 << (4 + 2 * s)) + 64);
            rd32(wdg_pkg::ADDR_CNT, 1 << (4 + 2 * s));
            rd32(wdg_pkg::ADDR_STAT, 32'h1);
        end
        $display("test intervals done");
        // mask, write-zero and write-one on the flag, irq enable gating
        wr32(wdg_pkg::ADDR_MASK, 32'h0);
        chk(irq, 1'b0);
        wr32(wdg_pkg::ADDR_MASK, 32'h7);
        wr32(wdg_pkg::ADDR_STAT, 32'h0);
        chk(irq, 1'b1);
        wr32(wdg_pkg::ADDR_CTRL, 32'h380);
        chk(irq, 1'b0);
        rd32(wdg_pkg::ADDR_CTRL, 32'h388);
        wr32(wdg_pkg::ADDR_CTRL, 32'h8);
        rd32(wdg_pkg::ADDR_STAT, 32'h0);
        $display("test flags done");
        // random mask values; counter and an unmapped place ignore writes
        // zero the stopped counter first so its value is known
        wr32(wdg_pkg::ADDR_CTRL, 32'h1);
        repeat (16) @(posedge clk);
        rd32(wdg_pkg::ADDR_CNT, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            wr32(wdg_pkg::ADDR_MASK, lfsr);
            rd32(wdg_pkg::ADDR_MASK, {29'h0, lfsr[2:0]});
            wr32(wdg_pkg::ADDR_CNT, lfsr);
            wr32(8'h10, lfsr);
            rd32(8'h10, 32'h0);
        end
        rd32(wdg_pkg::ADDR_CNT, 32'h0);
        wr32(wdg_pkg::ADDR_MASK, 32'h7);
        $display("test random writes done");
        // powered down, no reset enable and no wake enable
        @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        wr32(wdg_pkg::ADDR_CTRL, 32'h81);
        repeat (8 * 30) @(posedge clk);
        chk(rst_cnt, 0);
        chk(wake_cnt, 0);
        rd32(wdg_pkg::ADDR_STAT, 32'h1);
        wr32(wdg_pkg::ADDR_STAT, 32'h7);
        $display("test no reset enable done");
        // a clear inside the grace window saves the chip
        wr32(wdg_pkg::ADDR_CTRL, 32'hc3);
        wait_for(0, 8 * 16 + 64);
        wr32(wdg_pkg::ADDR_CTRL, 32'hc3);
        repeat (16) @(posedge clk);
        wr32(wdg_pkg::ADDR_CTRL, 32'h0);
        repeat (8 * 12) @(posedge clk);
        chk(rst_cnt, 0);
        wr32(wdg_pkg::ADDR_STAT, 32'h7);
        $display("test grace clear done");
        // wake from power-down, then no clear: chip reset follows
        wr32(wdg_pkg::ADDR_CTRL, 32'hd3);
        wait_for(0, 8 * 16 + 64);
        wait_for(1, 8 * GRACE + 64);
        chk(n, 8 * GRACE);
        chk(wake_cnt, 1);
        chk(power_down, 1'b0);
        wait_for(2, 8 * BARK + 64);
        chk(n, 8 * BARK);
        // the reset generator books the length one edge after the fall
        @(posedge clk);
        #1;
        chk(rst_len, BARK);
        chk(rst_cnt, 1);
        rd32(wdg_pkg::ADDR_STAT, 32'h7);
        rd32(wdg_pkg::ADDR_CTRL, 32'hc);
        wr32(wdg_pkg::ADDR_STAT, 32'h7);
        rd32(wdg_pkg::ADDR_STAT, 32'h0);
        $display("test wake and reset done");
        summarize();
    end
endmodule // wdg_top_tb
